// *** cwg_output_modes.sv ***
// Operation
// - three-bit field picks one of six behaviours
// - half-bridge: A true, B inverse, dead band
// - half-bridge: C, D same, own polarity
// - push-pull: pulses alternate A/B, no dead band
// - sequencer resets when disabled or shut down
// - first pulse after reset goes to A
// - push-pull: C follows A, D follows B
// - steering: unsteered outputs hold fixed level
// - polarity applies only to steered outputs
// - steer bits wait for rising edge in sync mode only, hold levels immediate
// - sync steering applies at next rising edge
// - async steering applies right after write
// - no dead band in steering modes
// - forward: A active, D modulated, B/C inactive
// - reverse: C active, B modulated, A/D inactive
// - direction may change while enabled
// - direction change waits for rising edge
// - statics swap, new output waits dead band
// - full-bridge dead band only on direction change
// - one bit selects dead-band clock source
// - four-bit field selects data source
// - enabling starts with all drives cleared
// - per-output polarity, overrides never inverted
// - two 6-bit dead-band counters
// - shutdown forces override levels in every mode
`timescale 1ns/10ps
`default_nettype none

module cwg_output_modes (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // software control fields
  input  wire cwg_pkg::ctrl_t                ctrl,
  // shutdown override from the auto-shutdown logic
  input  wire cwg_pkg::shutdown_t            shutdown,
  // candidate data sources and the fast oscillator tick
  input  wire logic [cwg_pkg::SRC_COUNT-1:0] sources,
  input  wire logic                          fastOscTick,
  // drives to the power switches
  output var  cwg_pkg::quad_t                drive,
  // keeps the fast oscillator running through sleep
  output logic                               oscKeepRun
);

  cwg_pkg::main_state_t st_reg;
  cwg_pkg::main_state_t st_next;

  logic        data;
  logic        rise;
  logic        fbMode;
  logic        wantRev;
  logic        dirChange;
  logic        dirNow;
  logic        ppSelB;
  logic [3:0]  strNow;
  logic        riseHold;
  logic        fallHold;
  logic        riseDone;
  logic        fallDone;
  logic        dbTick;
  logic        dbDone;
  cwg_pkg::quad_t raw;

  // full-bridge decode is needed by the core and by the checks
  function automatic logic isFullBridge(input cwg_pkg::mode_t m);
    isFullBridge = (m == cwg_pkg::MODE_FB_FWD) || (m == cwg_pkg::MODE_FB_REV);
  endfunction : isFullBridge

  // active level per output, set invert bit means active low
  function automatic cwg_pkg::quad_t applyPol(input cwg_pkg::quad_t r,
                                              input logic [3:0] inv);
    applyPol = r ^ inv;
  endfunction : applyPol

  // source choice and edge detect on the chosen data
  assign data   = sources[ctrl.srcSelect];
  assign rise   = data && !st_reg.dataPrev;
  assign dbTick = ctrl.dbClkSel ? fastOscTick : 1'b1;

  // direction decode; change only at a rising data edge
  assign fbMode    = isFullBridge(ctrl.mode);
  assign wantRev   = (ctrl.mode == cwg_pkg::MODE_FB_REV);
  assign dirChange = fbMode && rise && (wantRev != st_reg.dirRev);
  assign dirNow    = dirChange ? wantRev : st_reg.dirRev;

  // sync steering holds the old choice until the next rising edge
  assign strNow = ((ctrl.mode == cwg_pkg::MODE_STEER_SYNC) && !rise)
                  ? st_reg.strActive : ctrl.steerEnable;

  // push-pull slot chosen at the rising edge, kept for the pulse
  assign ppSelB = rise ? st_reg.ppNext : st_reg.ppCur;

  // counters serve half-bridge edges or the full-bridge direction gap
  always_comb begin
    riseHold = 1'b0;
    fallHold = 1'b0;
    if (ctrl.mode == cwg_pkg::MODE_HALF_BRIDGE) begin
      riseHold = data;
      fallHold = !data;
    end else if (fbMode) begin
      riseHold = st_reg.fbDbRun && st_reg.dirRev;
      fallHold = st_reg.fbDbRun && !st_reg.dirRev;
    end
  end

  assign dbDone = st_reg.dirRev ? riseDone : fallDone;

  deadband_timer u_rise_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .hold    (riseHold),
    .tick    (dbTick),
    .limit   (ctrl.riseCount),
    .done    (riseDone)
  );

  deadband_timer u_fall_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .hold    (fallHold),
    .tick    (dbTick),
    .limit   (ctrl.fallCount),
    .done    (fallDone)
  );

  // next state of the whole core
  always_comb begin
    st_next          = st_reg;
    raw              = cwg_pkg::QUAD_RESET;
    st_next.dataPrev = data;
    st_next.oscRun   = ctrl.dbClkSel && ctrl.enable;
    st_next.fbDbRun  = fbMode && (dirChange || (st_reg.fbDbRun && !dbDone));
    st_next.dirRev   = fbMode ? dirNow : wantRev;
    st_next.strActive = strNow;
    if (rise && (ctrl.mode == cwg_pkg::MODE_PUSH_PULL)) begin
      st_next.ppCur  = st_reg.ppNext;
      st_next.ppNext = !st_reg.ppNext;
    end
    case (ctrl.mode)
      cwg_pkg::MODE_HALF_BRIDGE: begin
        raw.a = data && riseDone;
        raw.b = !data && fallDone;
        raw.c = raw.a;
        raw.d = raw.b;
        st_next.drive = applyPol(raw, ctrl.invert);
      end
      cwg_pkg::MODE_PUSH_PULL: begin
        raw.a = data && !ppSelB;
        raw.b = data && ppSelB;
        raw.c = raw.a;
        raw.d = raw.b;
        st_next.drive = applyPol(raw, ctrl.invert);
      end
      cwg_pkg::MODE_STEER_ASYNC,
      cwg_pkg::MODE_STEER_SYNC: begin
        // no dead band here; the data goes straight out
        for (int i = 0; i < 4; i++) begin
          st_next.drive[i] = strNow[i] ? (data ^ ctrl.invert[i])
                                       : ctrl.steerHold[i];
        end
      end
      cwg_pkg::MODE_FB_FWD,
      cwg_pkg::MODE_FB_REV: begin
        // statics swap at once, the new modulated leg waits
        raw.a = !dirNow;
        raw.c = dirNow;
        raw.d = !dirNow && data && !st_next.fbDbRun;
        raw.b = dirNow && data && !st_next.fbDbRun;
        st_next.drive = applyPol(raw, ctrl.invert);
      end
      default: begin
        // unassigned codes idle at the inactive level
        st_next.drive = applyPol(cwg_pkg::QUAD_RESET, ctrl.invert);
      end
    endcase
    // shutdown outranks every mode, levels are not inverted
    if (shutdown.active) begin
      st_next.drive   = shutdown.level;
      st_next.ppNext  = 1'b0;
      st_next.ppCur   = 1'b0;
      st_next.fbDbRun = 1'b0;
    end
    // a disabled module sits with every drive cleared
    if (!ctrl.enable) begin
      st_next          = cwg_pkg::MAIN_RESET;
      st_next.dataPrev = data;
      st_next.dirRev   = wantRev;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= cwg_pkg::MAIN_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign drive      = st_reg.drive;
  assign oscKeepRun = st_reg.oscRun;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_running;
    ctrl.enable && !shutdown.active;
  endsequence

  sequence s_pp_first;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_PUSH_PULL) && rise && !st_reg.ppNext;
  endsequence

  property p_disabled_clear;
    !ctrl.enable |=> (drive == cwg_pkg::QUAD_RESET) && !st_reg.ppNext;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear)
    else $error("drives not cleared while disabled");

  property p_shutdown_override;
    ctrl.enable && shutdown.active |=> drive == $past(shutdown.level);
  endproperty
  a_shutdown_override: assert property (p_shutdown_override)
    else $error("shutdown level not driven");

  property p_pp_first_on_a;
    s_pp_first |=> drive.a == !$past(ctrl.invert[0]) && drive.b == $past(ctrl.invert[1]);
  endproperty
  a_pp_first_on_a: assert property (p_pp_first_on_a)
    else $error("first push-pull pulse not on A");

  property p_pp_alternate;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_PUSH_PULL) && rise
      |=> st_reg.ppNext != $past(st_reg.ppNext);
  endproperty
  a_pp_alternate: assert property (p_pp_alternate)
    else $error("push-pull sequencer did not advance");

  property p_pp_reset;
    ctrl.enable && shutdown.active |=> !st_reg.ppNext && !st_reg.ppCur;
  endproperty
  a_pp_reset: assert property (p_pp_reset)
    else $error("push-pull sequencer not reset by shutdown");

  property p_steer_hold;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_STEER_ASYNC) && !ctrl.steerEnable[2]
      |=> drive.c == $past(ctrl.steerHold[2]);
  endproperty
  a_steer_hold: assert property (p_steer_hold)
    else $error("unsteered output not at hold level");

  property p_steer_pol;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_STEER_ASYNC) && ctrl.steerEnable[0]
      |=> drive.a == ($past(data) ^ $past(ctrl.invert[0]));
  endproperty
  a_steer_pol: assert property (p_steer_pol)
    else $error("steered output polarity wrong");

  property p_sync_wait;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_STEER_SYNC) && !rise
      |=> st_reg.strActive == $past(st_reg.strActive);
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("sync steering changed between rising edges");

  property p_fwd_static;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_FB_FWD) && !st_reg.dirRev
      |=> drive.a == !$past(ctrl.invert[0]) && drive.b == $past(ctrl.invert[1])
          && drive.c == $past(ctrl.invert[2]);
  endproperty
  a_fwd_static: assert property (p_fwd_static)
    else $error("forward static outputs wrong");

  property p_dir_change;
    s_running ##0 dirChange && wantRev
      |=> st_reg.fbDbRun && drive.c == !$past(ctrl.invert[2])
          && drive.b == $past(ctrl.invert[1]) && drive.d == $past(ctrl.invert[3]);
  endproperty
  a_dir_change: assert property (p_dir_change)
    else $error("direction change sequence wrong");

  property p_dir_waits_edge;
    s_running ##0 fbMode && !rise |=> st_reg.dirRev == $past(st_reg.dirRev);
  endproperty
  a_dir_waits_edge: assert property (p_dir_waits_edge)
    else $error("direction changed without rising edge");

  property p_hb_inactive;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_HALF_BRIDGE) && !data
      |=> drive.a == $past(ctrl.invert[0]) && drive.c == $past(ctrl.invert[2]);
  endproperty
  a_hb_inactive: assert property (p_hb_inactive)
    else $error("half-bridge A active while data low");

  // a nonzero rising count keeps A off on the edge itself
  property p_hb_db_wait;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_HALF_BRIDGE) && rise
      && (ctrl.riseCount != 6'h00) && ($past(ctrl.mode) == cwg_pkg::MODE_HALF_BRIDGE)
      |=> drive.a == $past(ctrl.invert[0]);
  endproperty
  a_hb_db_wait: assert property (p_hb_db_wait)
    else $error("half-bridge A turned on inside dead band");

  property p_hb_copies;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_HALF_BRIDGE)
      |=> ((drive.c ^ $past(ctrl.invert[2])) == (drive.a ^ $past(ctrl.invert[0])))
          && ((drive.d ^ $past(ctrl.invert[3])) == (drive.b ^ $past(ctrl.invert[1])));
  endproperty
  a_hb_copies: assert property (p_hb_copies)
    else $error("half-bridge C or D not copying A or B");

  property p_pp_copies;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_PUSH_PULL)
      |=> ((drive.c ^ $past(ctrl.invert[2])) == (drive.a ^ $past(ctrl.invert[0])))
          && ((drive.d ^ $past(ctrl.invert[3])) == (drive.b ^ $past(ctrl.invert[1])));
  endproperty
  a_pp_copies: assert property (p_pp_copies)
    else $error("push-pull C or D not copying A or B");

  property p_osc_keep;
    ctrl.enable && ctrl.dbClkSel |=> oscKeepRun;
  endproperty
  a_osc_keep: assert property (p_osc_keep)
    else $error("fast oscillator not kept running");

  property p_async_take;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_STEER_ASYNC)
      |=> st_reg.strActive == $past(ctrl.steerEnable);
  endproperty
  a_async_take: assert property (p_async_take)
    else $error("async steering choice not taken at once");

  property p_fwd_mod;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_FB_FWD) && !st_reg.dirRev && !st_reg.fbDbRun
      |=> drive.d == ($past(data) ^ $past(ctrl.invert[3]));
  endproperty
  a_fwd_mod: assert property (p_fwd_mod)
    else $error("forward D not following data");

  property p_rev_static;
    s_running ##0 (ctrl.mode == cwg_pkg::MODE_FB_REV) && st_reg.dirRev
      |=> drive.a == $past(ctrl.invert[0]) && drive.c == !$past(ctrl.invert[2])
          && drive.d == $past(ctrl.invert[3]);
  endproperty
  a_rev_static: assert property (p_rev_static)
    else $error("reverse static outputs wrong");

endmodule : cwg_output_modes

`default_nettype wire

// *** cwg_pkg.sv ***
`default_nettype none

package cwg_pkg;

  // output behaviour selector, three-bit field
  typedef enum logic [2:0] {
    MODE_STEER_ASYNC = 3'h0,
    MODE_STEER_SYNC  = 3'h1,
    MODE_FB_FWD      = 3'h2,
    MODE_FB_REV      = 3'h3,
    MODE_HALF_BRIDGE = 3'h4,
    MODE_PUSH_PULL   = 3'h5
  } mode_t;

  // widths of the fields
  localparam int DB_WIDTH  = 6;
  localparam int SEL_WIDTH = 4;
  localparam int SRC_COUNT = 16;

  // reset values
  localparam logic [3:0]          QUAD_RESET   = 4'h0;
  localparam logic [DB_WIDTH-1:0] DB_CNT_RESET = 6'h00;

  // the four drives, one bit each
  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } quad_t;

  // software control fields, carried as one bundle
  typedef struct packed {
    logic                  enable;
    mode_t                 mode;
    logic [3:0]            invert;
    logic [3:0]            steerEnable;
    logic [3:0]            steerHold;
    logic [SEL_WIDTH-1:0]  srcSelect;
    logic                  dbClkSel;
    logic [DB_WIDTH-1:0]   riseCount;
    logic [DB_WIDTH-1:0]   fallCount;
  } ctrl_t;

  // override request from the shutdown logic
  typedef struct packed {
    logic       active;
    logic [3:0] level;
  } shutdown_t;

  // all state of the waveform core
  typedef struct packed {
    logic       dataPrev;
    logic       ppNext;
    logic       ppCur;
    logic [3:0] strActive;
    logic       dirRev;
    logic       fbDbRun;
    quad_t      drive;
    logic       oscRun;
  } main_state_t;

  // all state of one dead-band counter
  typedef struct packed {
    logic [DB_WIDTH-1:0] count;
  } timer_state_t;

  localparam main_state_t  MAIN_RESET  = '0;
  localparam timer_state_t TIMER_RESET = '0;

endpackage : cwg_pkg

`default_nettype wire

// *** deadband_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

module deadband_timer (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // request and timing
  input  wire logic                         hold,
  input  wire logic                         tick,
  input  wire logic [cwg_pkg::DB_WIDTH-1:0] limit,
  // result
  output logic                              done
);

  cwg_pkg::timer_state_t st_reg;
  cwg_pkg::timer_state_t st_next;

  // counts dead-band clock periods from zero while the request holds
  always_comb begin
    st_next = st_reg;
    if (!hold) begin
      st_next.count = cwg_pkg::DB_CNT_RESET; // a dropped request restarts the interval
    end else if (tick && (st_reg.count < limit)) begin
      st_next.count = st_reg.count + 6'h01;
    end
  end

  // a zero limit gives no dead band, except one clock on a full-bridge direction change
  assign done = hold && (st_reg.count >= limit);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= cwg_pkg::TIMER_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : deadband_timer

`default_nettype wire

// *** cwg_switch_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module cwg_switch_model (
  // clock
  input  wire logic           clk,
  // drives and polarity as wired to the switches
  input  wire cwg_pkg::quad_t drive,
  input  wire logic [3:0]     invert,
  // turn-on edges per switch, two bits each, a at the bottom
  output logic [7:0]          onEdges
);
  logic [3:0] onPrev = 4'h0;
  logic [3:0] onNow;

  initial onEdges = 8'h00;

  // a switch conducts when its drive sits at the active level
  assign onNow = drive ^ invert;

  // two bits per switch suffice; the bench only looks at short bursts
  always @(posedge clk) begin
    onPrev <= onNow;
    for (int k = 0; k < 4; k++) begin
      if (onNow[k] && !onPrev[k]) begin
        onEdges[2*k +: 2] <= onEdges[2*k +: 2] + 2'h1;
      end
    end
  end
endmodule : cwg_switch_model

`default_nettype wire

// *** complementary_waveform_modes_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module complementary_waveform_modes_tb_top;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               tick = 1'b0;
  logic [15:0]        srcBits = 16'h0000;
  logic [15:0]        seed = 16'h0015;
  logic [7:0]         onEdges;
  logic [7:0]         snap;
  logic               keepRun;
  cwg_pkg::ctrl_t     c = '0;
  cwg_pkg::ctrl_t     alt;
  cwg_pkg::shutdown_t sd = '0;
  cwg_pkg::quad_t     drive;
  int                 errTotal = 0;
  int                 checked = 0;
  int                 cycles = 0;

  // 4 ns clock
  always #2 clk = ~clk;

  cwg_output_modes i_cwg_output_modes (
    .clk(clk), .sys_rst(rst), .ctrl(c), .shutdown(sd), .sources(srcBits),
    .fastOscTick(tick), .drive(drive), .oscKeepRun(keepRun));

  cwg_switch_model i_cwg_switch_model (
    .clk(clk), .drive(drive), .invert(c.invert), .onEdges(onEdges));

  // slow dead-band tick every fourth cycle, and the hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    tick <= (cycles % 4 == 0);
    if (cycles == 9000) begin
      errTotal++;
      give_verdict();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // settled drive for data held long past any dead band
  function automatic cwg_pkg::quad_t expq(input cwg_pkg::ctrl_t k,
      input cwg_pkg::shutdown_t s, input logic d);
    logic [3:0] i;
    logic [3:0] r;
    i = k.invert;
    case (k.mode)
      cwg_pkg::MODE_STEER_ASYNC, cwg_pkg::MODE_STEER_SYNC:
        r = (k.steerEnable & ({4{d}} ^ i)) | (~k.steerEnable & k.steerHold);
      cwg_pkg::MODE_FB_FWD:      r = {i[3] ^ d, i[2], i[1], ~i[0]};
      cwg_pkg::MODE_FB_REV:      r = {i[3], ~i[2], i[1] ^ d, i[0]};
      cwg_pkg::MODE_HALF_BRIDGE: r = {~d, d, ~d, d} ^ i;
      default:                   r = i;
    endcase
    if (s.active) r = s.level;
    if (!k.enable) r = 4'h0;
    return r;
  endfunction : expq

  function automatic logic [7:0] addf(input logic [7:0] s, input logic [7:0] n);
    logic [7:0] r;
    for (int k = 0; k < 4; k++) r[2*k +: 2] = s[2*k +: 2] + n[2*k +: 2];
    return r;
  endfunction : addf

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // other sources get noise so a wrong select shows
  task automatic setData(input logic d);
    logic [15:0] v;
    seed = lfsr(seed);
    v = seed;
    v[c.srcSelect] = d;
    srcBits = v; // one write, so the chosen bit never glitches
  endtask : setData

  task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string m);
    checked++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : cmp

  task automatic cq(input cwg_pkg::quad_t e, input string m);
    cmp({4'h0, drive}, {4'h0, e}, m);
  endtask : cq

  task automatic ppPulse(input logic [7:0] inc);
    snap = onEdges;
    setData(1'b1);
    step(5);
    setData(1'b0);
    step(5);
    cmp(onEdges, addf(snap, inc), "push-pull");
  endtask : ppPulse

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    step(6);
    rst = 1'b0;
    cq(4'h0, "reset");
    // random modes; push-pull code excluded as its state is history
    for (int n = 0; n < 40; n++) begin
      seed = lfsr(seed);
      c.mode = cwg_pkg::mode_t'((seed[2:0] == 3'h5) ? 3'h4 : seed[2:0]);
      {c.dbClkSel, c.steerHold, c.steerEnable, c.invert} = seed[15:3];
      seed = lfsr(seed);
      c.srcSelect = seed[3:0];
      c.riseCount = {3'h0, seed[6:4]};
      c.fallCount = {3'h0, seed[9:7]};
      sd.active = (seed[11:10] == 2'h0);
      sd.level = seed[15:12];
      c.enable = (n % 9 != 4);
      setData(1'b0);
      step(3);
      setData(1'b1);
      step(40);
      cq(expq(c, sd, 1'b1), "high");
      cmp({7'h0, keepRun}, {7'h0, c.enable & c.dbClkSel}, "osc");
      setData(1'b0);
      step(40);
      cq(expq(c, sd, 1'b0), "low");
    end
    // direction change waits for a rise, then dead band on b
    c.enable = 1'b1;
    sd.active = 1'b0;
    c.mode = cwg_pkg::MODE_FB_FWD;
    c.dbClkSel = 1'b0;
    c.riseCount = 6'h05;
    setData(1'b1);
    step(10);
    setData(1'b0);
    step(3);
    alt = c;
    c.mode = cwg_pkg::MODE_FB_REV;
    step(4);
    cq(expq(alt, sd, 1'b0), "early");
    setData(1'b1);
    step(2);
    cq({c.invert[3], ~c.invert[2], c.invert[1], c.invert[0]}, "swap");
    step(10);
    cq(expq(c, sd, 1'b1), "reverse");
    // sync steering holds a mid-pulse change until the next rise
    c.mode = cwg_pkg::MODE_STEER_SYNC;
    c.steerEnable = 4'hf;
    c.steerHold = c.invert; // hold differs from every steered level
    setData(1'b0);
    step(3);
    setData(1'b1);
    step(3);
    alt = c;
    c.steerEnable = 4'h0;
    step(3);
    cq(expq(alt, sd, 1'b1), "sync wait");
    setData(1'b0);
    step(3);
    setData(1'b1);
    step(3);
    cq(expq(c, sd, 1'b1), "sync take");
    // hold levels move at once, even between rising edges
    c.steerHold = ~c.invert;
    step(2);
    cq(expq(c, sd, 1'b1), "sync hold");
    // async steering cuts the pulse short
    c.mode = cwg_pkg::MODE_STEER_ASYNC;
    c.steerEnable = 4'hf;
    c.steerHold = c.invert;
    step(3);
    c.steerEnable = 4'h0;
    step(2);
    cq(expq(c, sd, 1'b1), "async cut");
    // push-pull alternation and sequencer restart
    c.enable = 1'b0;
    step(2);
    cq(4'h0, "off");
    c.enable = 1'b1;
    c.mode = cwg_pkg::MODE_PUSH_PULL;
    setData(1'b0);
    step(3);
    ppPulse(8'h11);
    ppPulse(8'h44);
    ppPulse(8'h11);
    sd.active = 1'b1;
    step(3);
    sd.active = 1'b0;
    step(3);
    ppPulse(8'h11);
    give_verdict();
  end
endmodule : complementary_waveform_modes_tb_top

`default_nettype wire
